// >>> mseq_branch.sv
/*
 * Branch address logic of the microcode sequencer: opcode map lookup,
 * split dispatch mux, skip, call/return stack and fault dispatch.
 * Assumes the control store sits outside and feeds fields back each
 * cycle; all inputs are synchronous to i_ref_clk.
 */
// Behaviour
// - Map lookup clocks with instruction load
// - Map is 512 by 36 synchronous ROM
// - Field-selected mux yields 12-bit dispatch address
// - Upper 8 bits chosen apart from lower 4
// - Decode dispatch takes whole target from map
// - Decode targets lie in 1400..1700 octal
// - Skip offset is 0000 or 0001 octal
// - Skip only ORs, never multiplexes
// - Read port always shows top entry
// - Write port always one past top
// - Call stores address, increments pointer
// - Return decrements pointer, shows entry beneath
// - Stack update completes in one cycle
// - Call pushes own address; return adds no offset
// - Fault handler resumes at faulting access
// - Fault codes 00, 01, 05; 03/07 unused
// - Fault codes 10, 11, 12, 13 octal
// - Memory clear op clears fault code
// - Fault forces next address to 7777
// - Reset holds microaddress at 0000
// - Next address ORs jump, skip, dispatch, fault
// - Control store spans 4096 words
`timescale 1ns/1ns
`default_nettype none
module mseq_branch (
    input wire logic i_ref_clk,            // CPU clock, 250 MHz
    input wire logic i_srst,               // Synchronous reset, high
    input wire logic [11:0] i_jump_field,  // Jump field of microword
    input wire logic i_ir_load,            // Load instruction register
    input wire logic [8:0] i_ir_opcode,    // Opcode being loaded
    input wire logic [1:0] i_disp_hi_sel,  // Upper dispatch select
    input wire logic [1:0] i_disp_lo_sel,  // Lower dispatch select
    input wire logic [7:0] i_disp_hi_field,// Upper field source
    input wire logic [3:0] i_disp_lo_cond, // Lower condition source
    input wire logic i_skip_en,            // Skip requested
    input wire logic i_skip_cond,          // Selected skip condition
    input wire logic i_call,               // Call request
    input wire logic i_ret,                // Return request
    input wire logic i_intr,               // Processor/ext/timer intr
    input wire logic i_missing_mem,        // Missing memory error
    input wire logic i_write_prot,         // Write to read-only page
    input wire logic i_page_absent,        // Page not present
    input wire logic i_timer_pend,         // Timer interrupt pending
    input wire logic i_priv_mismatch,      // Exec/user mismatch
    input wire logic i_memory_clear_op,    // Memory clear microop
    output logic [11:0] o_uaddr,           // Current microaddress
    output logic [11:0] o_return_addr,     // Top of stack
    output logic [3:0] o_fault_dispatch,   // Latched fault code
    output logic [35:0] o_opmap_word       // Opcode map word
);

    ////////////////////////////////////////////////////////////////////
    // Opcode map storage
    ////////////////////////////////////////////////////////////////////

    mseq_map_if map_bus ();           // Link to the map storage

    assign map_bus.load = i_ir_load;
    assign map_bus.opcode = i_ir_opcode;

    mseq_opcode_map_rom u_map (
        .i_ref_clk (i_ref_clk),
        .bus       (map_bus)
    );

    logic [11:0] map_target;          // Decode target from map
    assign map_target = map_bus.word[11:0];

    ////////////////////////////////////////////////////////////////////
    // Fault dispatch register
    ////////////////////////////////////////////////////////////////////

    logic [3:0] fault_ff;             // Latched fault code
    logic [3:0] nxt_fault;            // New code this cycle
    logic fault_now;                  // A new fault arrives

    // Priority encoder; bad-data codes 03/07 never produced
    always_comb begin
        nxt_fault = mseq_pkg::FD_NONE;
        if (i_priv_mismatch) begin
            nxt_fault = mseq_pkg::FD_PRIV_MISMATCH;
        end else if (i_page_absent && i_timer_pend) begin
            nxt_fault = mseq_pkg::FD_ABSENT_TIMER;
        end else if (i_page_absent) begin
            nxt_fault = mseq_pkg::FD_ABSENT;
        end else if (i_write_prot) begin
            nxt_fault = mseq_pkg::FD_WRITE_PROT;
        end else if (i_missing_mem) begin
            nxt_fault = mseq_pkg::FD_MISSING_MEM;
        end else if (i_intr) begin
            nxt_fault = mseq_pkg::FD_INTR;
        end
    end

    assign fault_now = (nxt_fault != mseq_pkg::FD_NONE);

    // New fault wins over a clear in the same cycle so none is lost
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            fault_ff <= mseq_pkg::FD_NONE;
        end else if (fault_now) begin
            fault_ff <= nxt_fault;
        end else if (i_memory_clear_op) begin
            fault_ff <= mseq_pkg::FD_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dispatch multiplexer, two independent halves
    ////////////////////////////////////////////////////////////////////

    logic [7:0] disp_hi;              // Upper eight dispatch bits
    logic [3:0] disp_lo;              // Lower four dispatch bits
    logic [11:0] disp_addr;           // Full dispatch address

    // Upper half
    always_comb begin
        disp_hi = 8'h00;
        unique case (mseq_pkg::mseq_hi_sel_t'(i_disp_hi_sel))
            mseq_pkg::MSEQ_HI_NONE: begin
                disp_hi = 8'h00;
            end
            mseq_pkg::MSEQ_HI_FIELD: begin
                disp_hi = i_disp_hi_field;
            end
            mseq_pkg::MSEQ_HI_OPCODE: begin
                disp_hi = map_target[11:4];
            end
            default: begin
                disp_hi = 8'h00;      // Code 3 is unused
            end
        endcase
    end

    // Lower half, chosen without regard to the upper half
    always_comb begin
        disp_lo = 4'h0;
        unique case (mseq_pkg::mseq_lo_sel_t'(i_disp_lo_sel))
            mseq_pkg::MSEQ_LO_NONE: begin
                disp_lo = 4'h0;
            end
            mseq_pkg::MSEQ_LO_COND: begin
                disp_lo = i_disp_lo_cond;
            end
            mseq_pkg::MSEQ_LO_FAULT: begin
                disp_lo = fault_ff;   // Fault handler sorts causes
            end
            mseq_pkg::MSEQ_LO_OPCODE: begin
                disp_lo = map_target[3:0];
            end
        endcase
    end

    assign disp_addr = {disp_hi, disp_lo};

    ////////////////////////////////////////////////////////////////////
    // Skip offset
    ////////////////////////////////////////////////////////////////////

    logic [11:0] skip_offset;         // Either 0000 or 0001 octal

    // Only bit 0 can ever be set, so even targets step to odd ones
    assign skip_offset = (i_skip_en && i_skip_cond) ?
        mseq_pkg::SKIP_TAKEN : mseq_pkg::SKIP_NONE;

    ////////////////////////////////////////////////////////////////////
    // Call/return stack, one read and one write slot
    ////////////////////////////////////////////////////////////////////

    logic [11:0] stack_mem [0:mseq_pkg::STACK_DEPTH-1]; // Stack storage
    logic [3:0] sp_ff;                // Index of top entry
    logic [3:0] wr_ptr;               // Always one past top

    assign wr_ptr = sp_ff + 4'h1;

    // Write port is fixed above the top; no address swapping needed.
    // Slot zero is cleared in reset so the idle read port never shows
    // uninitialised storage; call and return together write nothing.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            stack_mem[0] <= mseq_pkg::UADDR_RESET;
        end else if (i_call && !i_ret) begin
            stack_mem[wr_ptr] <= o_uaddr;
        end
    end

    // Pointer wraps; overflow and underflow are silently allowed
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sp_ff <= 4'h0;
        end else if (i_call && !i_ret) begin
            sp_ff <= sp_ff + 4'h1;
        end else if (i_ret && !i_call) begin
            sp_ff <= sp_ff - 4'h1;
        end
    end

    // Read port always follows the top entry
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_return_addr <= 12'h000;
        end else if (i_call && !i_ret) begin
            o_return_addr <= o_uaddr;
        end else if (i_ret && !i_call) begin
            o_return_addr <= stack_mem[sp_ff - 4'h1];
        end else begin
            o_return_addr <= stack_mem[sp_ff];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next microaddress
    ////////////////////////////////////////////////////////////////////

    logic [11:0] nxt_uaddr;           // OR of all contributions

    // Fault sets every bit; re-entry reruns the faulting access
    assign nxt_uaddr = i_jump_field | skip_offset | disp_addr |
        (fault_now ? mseq_pkg::UADDR_FAULT : 12'h000);

    // Reset pins execution at address zero of the 4096-word store
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_uaddr <= mseq_pkg::UADDR_RESET;
        end else begin
            o_uaddr <= nxt_uaddr;
        end
    end

    // Registered copies for the outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_fault_dispatch <= mseq_pkg::FD_NONE;
            o_opmap_word <= 36'h000000000;
        end else begin
            o_fault_dispatch <= fault_ff;
            o_opmap_word <= map_bus.word;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////

    a_reset_addr_zero: assert property (@(posedge i_ref_clk)
        i_srst |=> o_uaddr == 12'h000)
        else $error("address not zero after reset");

    a_fault_vector: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) fault_now |=> o_uaddr == 12'hfff)
        else $error("fault did not vector to 7777");

    a_skip_sets_lsb: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) (i_skip_en && i_skip_cond) |=> o_uaddr[0])
        else $error("taken skip left bit 0 clear");

    a_or_keeps_jump: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) 1'b1 |=>
        ((o_uaddr & $past(i_jump_field)) == $past(i_jump_field)))
        else $error("jump bits cleared");

    a_call_then_top: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) (i_call && !i_ret) |=>
        o_return_addr == $past(o_uaddr))
        else $error("call address not on top");

    a_call_ret_pair: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) (i_call && !i_ret) ##1 (!i_call && !i_ret)
        ##1 (i_ret && !i_call) |=> sp_ff == $past(sp_ff, 3))
        else $error("pointer not restored by return");

    a_memory_clear_op_clears: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) (i_memory_clear_op && !fault_now) |=>
        fault_ff == 4'h0)
        else $error("memory clear did not clear fault");

    a_no_bad_data: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) fault_ff != 4'h3 && fault_ff != 4'h7)
        else $error("reserved fault code seen");

    a_map_in_range: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) $past(i_ir_load) |->
        (map_target >= 12'h300 && map_target <= 12'h3c0))
        else $error("decode target outside window");

    c_call: cover property (@(posedge i_ref_clk) i_call && !i_srst);
    c_ret: cover property (@(posedge i_ref_clk) i_ret && !i_srst);
    c_fault: cover property (@(posedge i_ref_clk) fault_now && !i_srst);
    c_skip: cover property (@(posedge i_ref_clk)
        i_skip_en && i_skip_cond && !i_srst);

endmodule : mseq_branch
`default_nettype wire

// >>> mseq_fault_src_model.sv
/*
 * Datapath fault source model: turns a fault kind number into cause lines.
 * Assumes the bench changes the kind only just after a falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module mseq_fault_src_model (
    input wire logic [2:0] i_kind, // 0 none, 1..6 fault kinds
    output logic o_intr,           // Interrupt cause
    output logic o_missing_mem,    // Missing memory cause
    output logic o_write_prot,     // Write protect cause
    output logic o_page_absent,    // Page absent cause
    output logic o_timer_pend,     // Timer pending cause
    output logic o_priv_mismatch   // Privilege mismatch cause
);
    ////////////////////////////////////////////////////////////////////////
    // Level causes; kind 4 raises two lines to exercise the combined code.
    // Uncorrectable data is never raised, so its codes cannot appear.
    always_comb begin
        o_intr = (i_kind == 3'h1);
        o_missing_mem = (i_kind == 3'h2);
        o_write_prot = (i_kind == 3'h3);
        o_page_absent = (i_kind == 3'h4) || (i_kind == 3'h5);
        o_timer_pend = (i_kind == 3'h4);
        o_priv_mismatch = (i_kind == 3'h6);
    end
endmodule : mseq_fault_src_model
`default_nettype wire

// >>> mseq_map_if.sv
/*
 * Interface between the sequencer and its opcode map storage.
 * Assumes both ends share the CPU clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface mseq_map_if;
    logic load;               // Instruction register load strobe
    logic [8:0] opcode;       // Opcode being loaded
    logic [35:0] word;        // Registered map word

    modport owner (output load, output opcode, input word);
    modport store (input load, input opcode, output word);
endinterface : mseq_map_if
`default_nettype wire

// >>> mseq_opcode_map_rom.sv
/*
 * Opcode map storage: 512 words of 36 bits, synchronous read only.
 * Assumes contents are filled by the build flow through the table below.
 */
`timescale 1ns/1ns
`default_nettype none
module mseq_opcode_map_rom (
    input wire logic i_ref_clk,   // CPU clock
    mseq_map_if.store bus         // Lookup port
);

    logic [35:0] rom_mem [0:mseq_pkg::OPMAP_DEPTH-1]; // Constant contents
    logic [35:0] word_ff;         // Registered read data

    // Default table places every target inside the decode window
    generate
        for (genvar g = 0; g < mseq_pkg::OPMAP_DEPTH; g++) begin : g_fill
            assign rom_mem[g] = {24'h000000,
                mseq_pkg::OPMAP_TGT_LO | 12'(g % 64)};
        end
    endgenerate

    // Read on the same edge that loads the instruction register
    always_ff @(posedge i_ref_clk) begin
        if (bus.load) begin
            word_ff <= rom_mem[bus.opcode];
        end
    end

    assign bus.word = word_ff;

endmodule : mseq_opcode_map_rom
`default_nettype wire

// >>> mseq_pkg.sv
/*
 * Shared constants and types for the microcode sequencer branch logic.
 * Assumes a single clock domain and a synchronous reset in every user.
 */
package mseq_pkg;

    // Address space of the control store
    localparam int UADDR_W = 12;
    localparam int CSTORE_WORDS = 4096;
    localparam logic [11:0] UADDR_RESET = 12'h000;
    localparam logic [11:0] UADDR_FAULT = 12'hfff;
    localparam logic [11:0] SKIP_NONE = 12'h000;
    localparam logic [11:0] SKIP_TAKEN = 12'h001;

    // Opcode map storage shape
    localparam int OPMAP_DEPTH = 512;
    localparam int OPMAP_AW = 9;
    localparam int OPMAP_W = 36;
    localparam int OPMAP_TGT_LSB = 0;
    localparam logic [11:0] OPMAP_TGT_LO = 12'h300;
    localparam logic [11:0] OPMAP_TGT_HI = 12'h3c0;

    // Stack shape
    localparam int STACK_DEPTH = 16;
    localparam int STACK_PW = 4;

    // Fault dispatch codes, octal values shown in hex
    localparam logic [3:0] FD_NONE = 4'h0;
    localparam logic [3:0] FD_INTR = 4'h1;
    localparam logic [3:0] FD_MISSING_MEM = 4'h5;
    localparam logic [3:0] FD_WRITE_PROT = 4'h8;
    localparam logic [3:0] FD_ABSENT_TIMER = 4'h9;
    localparam logic [3:0] FD_ABSENT = 4'ha;
    localparam logic [3:0] FD_PRIV_MISMATCH = 4'hb;

    // Upper dispatch selector
    typedef enum logic [1:0] {
        MSEQ_HI_NONE,
        MSEQ_HI_FIELD,
        MSEQ_HI_OPCODE
    } mseq_hi_sel_t;

    // Lower dispatch selector
    typedef enum logic [1:0] {
        MSEQ_LO_NONE,
        MSEQ_LO_COND,
        MSEQ_LO_FAULT,
        MSEQ_LO_OPCODE
    } mseq_lo_sel_t;

endpackage : mseq_pkg

// >>> tb.sv
/*
 * Self-checking bench for the sequencer branch logic.
 * Assumes inputs settle half a cycle before each rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct packed {
        logic [11:0] jmp; // Jump field
        logic sk_en;      // Skip request
        logic sk_c;       // Skip condition
        logic [1:0] hs;   // Upper select
        logic [1:0] ls;   // Lower select
        logic [7:0] hf;   // Upper field
        logic [3:0] lc;   // Lower condition
        logic [11:0] exp; // Expected next address
    } mseq_row_t;
    localparam mseq_row_t ROWS [10] = '{
    '{12'h100, 1'b0, 1'b0, 2'h0, 2'h0, 8'h00, 4'h0, 12'h100},
    '{12'h040, 1'b1, 1'b1, 2'h0, 2'h0, 8'h00, 4'h0, 12'h041},
    '{12'h041, 1'b1, 1'b1, 2'h0, 2'h0, 8'h00, 4'h0, 12'h041},
    '{12'h040, 1'b1, 1'b0, 2'h0, 2'h0, 8'h00, 4'h0, 12'h040},
    '{12'h040, 1'b0, 1'b1, 2'h0, 2'h0, 8'h00, 4'h0, 12'h040},
    '{12'h000, 1'b0, 1'b0, 2'h1, 2'h0, 8'ha5, 4'hf, 12'ha50},
    '{12'h000, 1'b0, 1'b0, 2'h0, 2'h1, 8'hff, 4'h6, 12'h006},
    '{12'h800, 1'b0, 1'b0, 2'h1, 2'h1, 8'h12, 4'h3, 12'h923},
    '{12'h000, 1'b0, 1'b0, 2'h3, 2'h0, 8'hff, 4'h0, 12'h000},
    '{12'h0f0, 1'b1, 1'b1, 2'h1, 2'h0, 8'h0f, 4'h0, 12'h0f1}
    };
    localparam logic [8:0] OPS [4] = '{9'h000, 9'h1ab, 9'h03f, 9'h1ff};
    localparam logic [3:0] FC [6] = '{4'h1, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb};

    logic clk = 1'b0;            // CPU clock
    logic srst = 1'b1;           // Reset, held from time zero
    logic [11:0] jump = 12'h000; // Jump field
    logic ir_load = 1'b0;        // Instruction load
    logic [8:0] opcode = 9'h000; // Opcode
    logic [1:0] hi_sel = 2'h0;   // Upper select
    logic [1:0] lo_sel = 2'h0;   // Lower select
    logic [7:0] hi_field = 8'h00;
    logic [3:0] lo_cond = 4'h0;
    logic skip_en = 1'b0;
    logic skip_cond = 1'b0;
    logic call = 1'b0;
    logic ret = 1'b0;
    logic mclr = 1'b0;           // Memory clear op
    logic [2:0] kind = 3'h0;     // Fault kind for the model
    logic intr, mmem, wprot, absent, tpend, priv;
    logic [11:0] uaddr;
    logic [11:0] raddr;
    logic [3:0] fcode;
    logic [35:0] opword;
    logic [11:0] tgt;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    always #2 clk = ~clk;

    mseq_fault_src_model i_mseq_fault_src_model (.i_kind(kind),
        .o_intr(intr), .o_missing_mem(mmem), .o_write_prot(wprot),
        .o_page_absent(absent), .o_timer_pend(tpend),
        .o_priv_mismatch(priv));

    mseq_branch i_mseq_branch (.i_ref_clk(clk), .i_srst(srst),
        .i_jump_field(jump), .i_ir_load(ir_load), .i_ir_opcode(opcode),
        .i_disp_hi_sel(hi_sel), .i_disp_lo_sel(lo_sel),
        .i_disp_hi_field(hi_field), .i_disp_lo_cond(lo_cond),
        .i_skip_en(skip_en), .i_skip_cond(skip_cond), .i_call(call),
        .i_ret(ret), .i_intr(intr), .i_missing_mem(mmem),
        .i_write_prot(wprot), .i_page_absent(absent),
        .i_timer_pend(tpend), .i_priv_mismatch(priv),
        .i_memory_clear_op(mclr), .o_uaddr(uaddr),
        .o_return_addr(raddr), .o_fault_dispatch(fcode),
        .o_opmap_word(opword));

    ////////////////////////////////////////////////////////////////////////
    // One full cycle, from falling edge to falling edge
    task automatic cyc;
        @(negedge clk);
    endtask : cyc

    task automatic cmp_addr(input string what, input logic [11:0] e,
                            input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_addr

    task automatic cmp_code(input string what, input logic [3:0] e,
                            input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_code

    // Runs the word at address a, then calls from it
    task automatic push(input logic [11:0] a);
        jump = a;
        cyc();
        call = 1'b1;
        cyc();
        call = 1'b0;
    endtask : push

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Whole run needs under a hundred cycles; this ceiling cuts a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("[ERR] run length expected 3000 seen longer");
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        jump = 12'h5a5;
        repeat (8) cyc();
        cmp_addr("reset address", 12'h000, uaddr);
        cmp_addr("reset top", 12'h000, raddr);
        cmp_code("reset code", 4'h0, fcode);
        srst = 1'b0;
        cyc();
        cmp_addr("first address", 12'h5a5, uaddr);
        cmp_addr("idle top", 12'h000, raddr);
        $display("test reset done");
        foreach (ROWS[k]) begin
            jump = ROWS[k].jmp;
            skip_en = ROWS[k].sk_en;
            skip_cond = ROWS[k].sk_c;
            hi_sel = ROWS[k].hs;
            lo_sel = ROWS[k].ls;
            hi_field = ROWS[k].hf;
            lo_cond = ROWS[k].lc;
            cyc();
            cmp_addr("next address", ROWS[k].exp, uaddr);
        end
        {skip_en, skip_cond, hi_sel, lo_sel} = 6'h00;
        $display("test table done");
        // Decode read in the very cycle after the load
        foreach (OPS[k]) begin
            jump = 12'h000;
            opcode = OPS[k];
            ir_load = 1'b1;
            cyc();
            ir_load = 1'b0;
            opcode = ~OPS[k];
            hi_sel = 2'h2;
            lo_sel = 2'h3;
            cyc();
            tgt = 12'h300 | {6'h00, OPS[k][5:0]};
            cmp_addr("decode target", tgt, uaddr);
            cmp_addr("map word", tgt, opword[11:0]);
            cmp_addr("target range", 12'h001, {11'h000,
                (uaddr >= 12'h300 && uaddr <= 12'h3c0)});
            hi_sel = 2'h0;
            lo_sel = 2'h0;
        end
        $display("test decode done");
        push(12'h111);
        cmp_addr("pushed top", 12'h111, raddr);
        push(12'h222);
        cmp_addr("second top", 12'h222, raddr);
        {call, ret} = 2'b11;
        cyc();
        {call, ret} = 2'b00;
        cmp_addr("both requests", 12'h222, raddr);
        ret = 1'b1;
        cyc();
        ret = 1'b0;
        cmp_addr("popped top", 12'h111, raddr);
        cyc();
        cmp_addr("standing top", 12'h111, raddr);
        // Call, one idle cycle, then return: pointer must come back
        push(12'h333);
        cyc();
        cmp_addr("third top", 12'h333, raddr);
        ret = 1'b1;
        cyc();
        ret = 1'b0;
        cmp_addr("pop after idle", 12'h111, raddr);
        $display("test stack done");
        for (int k = 0; k < 6; k++) begin
            jump = 12'h010;
            kind = 3'(k + 1);
            cyc();
            cmp_addr("fault vector", 12'hfff, uaddr);
            kind = 3'h0;
            jump = 12'h000;
            lo_sel = 2'h2;
            cyc();
            cmp_addr("fault dispatch", {8'h00, FC[k]}, uaddr);
            cmp_code("fault code", FC[k], fcode);
            mclr = 1'b1;
            cyc();
            mclr = 1'b0;
            cyc();
            cmp_code("cleared code", 4'h0, fcode);
            cmp_addr("cleared dispatch", 12'h000, uaddr);
            lo_sel = 2'h0;
        end
        // A new fault in the clearing cycle must win
        kind = 3'h5;
        mclr = 1'b1;
        cyc();
        kind = 3'h0;
        mclr = 1'b0;
        cyc();
        cmp_code("fault beats clear", 4'ha, fcode);
        $display("test fault done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
